// [core/mac_side_pkg.sv]
// constants and types shared by the mac-side media interface
// assumes a 50 mhz system clock; nothing else is included
package mac_side_pkg;
	// --------------------------------------------------------------
	// interface modes and speeds
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_MII = 2'h0,
		MODE_RMII = 2'h1,
		MODE_RGMII = 2'h2
	} mode_e;

	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam int SYS_CLK_HZ = 50000000;
	localparam int FAST_CLK_HZ = 25000000;
	localparam int SLOW_CLK_HZ = 2500000;
	// half period of the generated transmit clock, in system cycles
	localparam logic [4:0] FAST_HALF = 5'(SYS_CLK_HZ / FAST_CLK_HZ / 2);
	localparam logic [4:0] SLOW_HALF = 5'(SYS_CLK_HZ / SLOW_CLK_HZ / 2);

	// --------------------------------------------------------------
	// station address strap
	// --------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [3:0] STRAP_UPPER_RESET = 4'h0;
	localparam logic STRAP_LOW_RESET = 1'h1;
	localparam logic [4:0] STRAP_DEFAULT = 5'h01;

	// --------------------------------------------------------------
	// data path
	// --------------------------------------------------------------
	localparam int NIB_W = 4;
	localparam int FIFO_DEPTH = 8;
	// word: error flag above the nibble
	localparam int WORD_W = NIB_W + 1;
	// nibble delivered in place of data when the line reports an error
	localparam logic [3:0] ERR_NIBBLE = 4'he;
endpackage

// [core/nibble_fifo.sv]
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a clock enable shared with its user
`timescale 1ns/1ps
module nibble_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic doWr;
	logic doRd;

	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign doWr = clkEn && inValid && inReady;
	assign doRd = clkEn && outValid && outReady;

	always_ff @(posedge clk_sys) begin
		if (doWr) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doWr) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (doRd) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end
endmodule

// [core/mac_media_if.sv]
// mac-facing media interface of a 10/100 transceiver
// assumes line-side decoded nibbles arrive on clk_sys with valid/ready,
// and that the mac's pins reach here unsynchronised
`timescale 1ns/1ps
module mac_media_if
	import mac_side_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic [1:0] modeSel,
	input wire logic speedFast,
	input wire logic fullDuplex,
	input wire logic lineActive,
	input wire logic lineValid,
	output logic lineReady,
	input wire logic [3:0] lineNibble,
	input wire logic lineErr,
	input wire logic txClkIn,
	output logic txClkOut,
	output logic txClkOe_n,
	input wire logic txEn,
	input wire logic [3:0] txData,
	output logic txDataValid,
	output logic [3:0] txNibble,
	output logic txError,
	output logic rxClk,
	output logic rxCtrl,
	output logic rxErr,
	output logic [3:0] rxData,
	output logic [3:0] rxDataOe_n,
	input wire logic [3:0] rxDataPin,
	output logic carrierSense,
	output logic collision,
	output logic collisionOe_n,
	input wire logic collisionPin,
	output logic [4:0] station_address_strap
);
	// ----------------------------------------------------------
	// state
	// ----------------------------------------------------------
	typedef struct packed {
		logic outOfReset;
		logic strapDone;
		logic [4:0] strap;
		logic [4:0] divCnt;
		logic genClk;
		logic [2:0] txClkSync;
		logic [1:0] txEnSync;
		logic [7:0] txDataSync;
		logic txEnRise;
		logic [3:0] txNibble;
		logic txDataValid;
		logic txError;
		logic rxClk;
		logic rxCtrl;
		logic rxErr;
		logic [3:0] rxData;
		logic rxHold;
		logic rxHoldErr;
		logic carrierSense;
		logic collision;
		logic [1:0] rmiiPhase;
	} state_s;

	state_s st;
	state_s next_st;
	logic fifoValid;
	logic fifoReady;
	logic [WORD_W-1:0] fifoWord;
	mode_e mode;

	assign mode = mode_e'(modeSel);

	// ----------------------------------------------------------
	// receive buffer between line decoder and mac pins
	// ----------------------------------------------------------
	nibble_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.inValid(lineValid),
		.inReady(lineReady),
		.inData({lineErr, lineNibble}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoWord)
	);

	// a nibble is taken in the first cycle of the generated clock's low phase, every fourth cycle in rmii
	function automatic logic nibble_slot(input state_s s, input mode_e m);
		if (m == MODE_RMII) begin
			return s.rmiiPhase == 2'h0;
		end
		return s.genClk == 1'b0 && s.divCnt == 5'h0;
	endfunction

	assign fifoReady = clkEn && st.outOfReset && nibble_slot(st, mode);

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	always_comb begin
		logic [4:0] half;
		logic [3:0] nib;
		logic txActive;
		half = speedFast ? FAST_HALF : SLOW_HALF;
		nib = '0;
		txActive = 1'b0;
		next_st = st;
		next_st.outOfReset = 1'b1;
		// straps are caught once, the first cycle after release
		if (!st.strapDone) begin
			next_st.strapDone = 1'b1;
			next_st.strap = {rxDataPin, collisionPin};
		end
		// divider of the reference gives fixed-phase clocks
		if (st.divCnt == half - 5'h1 || st.divCnt >= half) begin
			next_st.divCnt = '0;
			next_st.genClk = ~st.genClk;
		end else begin
			next_st.divCnt = st.divCnt + 5'h1;
		end
		next_st.rmiiPhase = st.rmiiPhase + 2'h1;
		// mac pins pass two flops before use
		next_st.txClkSync = {st.txClkSync[1:0], txClkIn};
		next_st.txEnSync = {st.txEnSync[0], txEn};
		next_st.txDataSync = {st.txDataSync[3:0], txData};
		txActive = st.txEnSync[1];
		next_st.txEnRise = 1'b0;
		if (mode == MODE_RGMII) begin
			// sample control on both edges of the mac's clock
			if (st.txClkSync[2:1] == 2'b01) begin
				next_st.txDataValid = st.txEnSync[1];
				next_st.txNibble = st.txDataSync[7:4];
				next_st.txEnRise = 1'b1;
			end
			if (st.txClkSync[2:1] == 2'b10) begin
				next_st.txError = st.txEnSync[1] ^ st.txDataValid;
			end
		end else if (nibble_slot(st, mode)) begin
			next_st.txDataValid = st.txEnSync[1];
			next_st.txNibble = (mode == MODE_RMII) ? {2'h0, st.txDataSync[5:4]} : st.txDataSync[7:4];
			next_st.txError = 1'b0;
		end
		// receive side, launched with the rising generated edge at the fast rate, one cycle after the falling one at the slow rate
		if (fifoReady) begin
			next_st.rxHold = fifoValid;
			next_st.rxHoldErr = fifoValid && fifoWord[NIB_W];
			nib = fifoWord[NIB_W] ? ERR_NIBBLE : fifoWord[NIB_W-1:0];
			next_st.rxData = fifoValid ? nib : 4'h0;
			if (mode == MODE_RMII) begin
				next_st.rxData = fifoValid ? {2'h0, nib[1:0]} : 4'h0;
			end
			next_st.rxErr = (mode != MODE_RGMII) && fifoValid && fifoWord[NIB_W];
		end
		next_st.rxClk = (mode == MODE_RMII) ? 1'b0 : next_st.genClk;
		if (mode == MODE_RGMII) begin
			// valid on high phase, valid xor error on low phase
			next_st.rxCtrl = next_st.genClk ? next_st.rxHold : (next_st.rxHold ^ next_st.rxHoldErr);
		end else if (mode == MODE_RMII) begin
			next_st.rxCtrl = next_st.rxHold || lineActive;
		end else begin
			next_st.rxCtrl = next_st.rxHold;
		end
		next_st.carrierSense = (mode == MODE_MII) && (lineActive || txActive);
		next_st.collision = (mode != MODE_RMII) && !fullDuplex && lineActive && txActive;
	end

	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.strap <= {STRAP_UPPER_RESET, STRAP_LOW_RESET};
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------
	// pins
	// ----------------------------------------------------------
	always_comb begin
		// low enable means driving; tx clock driven low in reset, input in rmii and rgmii after; strap pins released in reset
		txClkOut = (mode == MODE_MII) && st.outOfReset && st.genClk;
		txClkOe_n = st.outOfReset && (mode != MODE_MII);
		rxDataOe_n = st.outOfReset ? 4'h0 : 4'hf;
		collisionOe_n = !st.outOfReset;
	end

	assign txDataValid = st.txDataValid;
	assign txNibble = st.txNibble;
	assign txError = st.txError;
	assign rxClk = st.rxClk;
	assign rxCtrl = st.rxCtrl;
	assign rxErr = st.rxErr;
	assign rxData = st.rxData;
	assign carrierSense = st.carrierSense;
	assign collision = st.collision;
	assign station_address_strap = st.strapDone ? st.strap : STRAP_DEFAULT;
endmodule

// [tb/mac_media_monitor.sv]
// checker on the ports of the mac-side media interface
// assumes clkEn is held high by the bench
`timescale 1ns/1ps
module mac_media_monitor
	import mac_side_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] modeSel,
	input wire logic speedFast,
	input wire logic fullDuplex,
	input wire logic lineActive,
	input wire logic txClkOut,
	input wire logic txClkOe_n,
	input wire logic rxErr,
	input wire logic [3:0] rxData,
	input wire logic [3:0] rxDataOe_n,
	input wire logic carrierSense,
	input wire logic collision,
	input wire logic [4:0] station_address_strap
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire mii = modeSel == MODE_MII;
	wire rgm = modeSel == MODE_RGMII;
	// collision and carrier follow the line every cycle at either rate; these three checks run at the fast rate only
	sequence fastMii; (mii && speedFast)[*6]; endsequence
	sequence slowRise; (mii && !speedFast)[*8] ##0 $rose(txClkOut); endsequence
	a_fast_txclk_toggle: assert property (fastMii |-> txClkOut != $past(txClkOut)) else $error("fast clock stuck");
	a_slow_txclk_high: assert property (slowRise |-> txClkOut[*8] ##3 !txClkOut) else $error("slow high phase");
	a_mii_drives_txclk: assert property (mii[*2] |-> !txClkOe_n) else $error("tx clock not driven");
	a_rgmii_txclk_in: assert property (rgm[*4] |-> txClkOe_n) else $error("tx clock still driven");
	a_idle_no_col: assert property ((speedFast && !lineActive)[*4] |-> !collision) else $error("idle collision");
	a_active_carrier: assert property ((mii && speedFast && lineActive)[*4] |-> carrierSense) else $error("no crs");
	a_full_no_col: assert property ((speedFast && fullDuplex)[*4] |-> !collision) else $error("full collision");
	a_rgmii_no_rxerr: assert property (rgm[*3] |-> !rxErr) else $error("rx error in rgmii");
	a_err_corrupts: assert property (mii && rxErr |-> rxData == ERR_NIBBLE) else $error("data not corrupted");
	a_strap_held: assert property ($past(rxDataOe_n) != 4'hf |-> $stable(station_address_strap)) else $error("strap moved");
endmodule
bind mac_media_if mac_media_monitor mon (.*);

// [tb/mac_model.sv]
// mac model: transmit pins and, in rgmii, the transmit clock
// assumes the bench picks the mode; its clock runs only inside frames
`timescale 1ns/1ps
module mac_model (
	input wire logic txClkOut,
	output logic txClkMac,
	output logic txEn,
	output logic [3:0] txData
);
	initial begin
		txClkMac = 1'b0;
		txEn = 1'b0;
		txData = 4'h0;
	end
	task automatic level(input logic v);
		txEn = v;
	endtask
	// launch after the device's rising edge, hold four periods
	task automatic mii_frame(input logic [3:0] n);
		@(posedge txClkOut) #2;
		txEn = 1'b1;
		txData = n;
		repeat (4) @(posedge txClkOut);
		#2 txEn = 1'b0;
		txData = ~n;
	endtask
	// 160 ns own clock: enable around rise, enable xor error around fall
	task automatic rgmii_frame(input logic [3:0] n, input logic err);
		txData = n;
		repeat (4) begin
			txEn = 1'b1;
			#40 txClkMac = 1'b1;
			#40 txEn = ~err;
			#40 txClkMac = 1'b0;
			#40;
		end
		txEn = 1'b0;
		txData = ~n;
	endtask
endmodule

// [tb/mac_media_if_test.sv]
// self-checking bench for the mac-side media interface
// assumes a 50 mhz clock; the mac model stands on the transmit pins
`timescale 1ns/1ps
module mac_media_if_test;
	import mac_side_pkg::*;
	logic clk_sys, rst_n, speedFast, fullDuplex, lineActive, lineValid, lineErr, lineReady;
	logic clkEn = 1'b1;
	logic [1:0] modeSel;
	logic [3:0] lineNibble, txData, txNibble, rxData, rxDataOe_n, rxDataPin;
	logic txClkOut, txClkOe_n, txClkMac, txClkIn, txEn, txDataValid, txError;
	logic rxClk, rxCtrl, rxErr, carrierSense, collision, collisionOe_n, collisionPin;
	logic [4:0] station_address_strap;
	int failures = 0, n_checks = 0, cycles = 0;
	// pin levels: receive pins pulled down, collision pulled up
	assign rxDataPin = rxData & ~rxDataOe_n;
	assign collisionPin = collisionOe_n | collision;
	assign txClkIn = txClkOe_n ? txClkMac : txClkOut;
	mac_media_if dut (.*);
	mac_model mdl (.txClkOut(txClkIn), .txClkMac(txClkMac), .txEn(txEn), .txData(txData));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic t_reset();
		chk("txclk oe", 0, txClkOe_n);
		chk("txclk", 0, txClkOut);
		chk("rx oe", 5'h0f, rxDataOe_n);
		rst_n = 1'b1;
		tick(3);
		chk("strap", STRAP_DEFAULT, station_address_strap);
	endtask
	task automatic t_txclk(input logic fast, input logic [4:0] half, input int cyc);
		int n;
		logic p;
		n = 0;
		speedFast = fast;
		tick(30);
		p = txClkOut;
		repeat (cyc) begin
			tick(1);
			n += int'(txClkOut === 1'b1 && p === 1'b0);
			p = txClkOut;
		end
		chk("txclk rises", 5'(cyc / (2 * half)), 5'(n));
	endtask
	task automatic t_rx(input logic [3:0] n, input logic e);
		int i;
		lineNibble = n;
		lineErr = e;
		lineValid = 1'b1;
		tick(1);
		lineValid = 1'b0;
		for (i = 0; i < 60 && rxCtrl !== 1'b1; i++) tick(1);
		chk("rx valid", 1, rxCtrl);
		chk("rx data", e ? ERR_NIBBLE : n, rxData);
		chk("rx err", e, rxErr);
		tick(4);
	endtask
	task automatic t_col();
		fullDuplex = 1'b0;
		lineActive = 1'b1;
		mdl.level(1'b1);
		tick(24);
		chk("carrier", 1, carrierSense);
		chk("collision", 1, collision);
		fullDuplex = 1'b1;
		tick(24);
		chk("full col", 0, collision);
		lineActive = 1'b0;
		tick(24);
		chk("tx carrier", 1, carrierSense);
		mdl.level(1'b0);
		tick(24);
	endtask
	// slow pops let the buffer fill until it refuses, then drain it
	task automatic t_fill();
		int i;
		lineValid = 1'b1;
		for (i = 0; i < 12 && lineReady === 1'b1; i++) tick(1);
		lineValid = 1'b0;
		chk("full refuses", 0, lineReady);
		tick(20 * (FIFO_DEPTH + 4));
		chk("drained", 1, lineReady);
	endtask
	// rgmii results stand after the frame, since the mac clock stops between frames
	task automatic t_tx(input logic rg, input logic [3:0] n, input logic e);
		int i;
		fork
			if (rg) mdl.rgmii_frame(n, e);
			else mdl.mii_frame(n);
			if (!rg) begin
				for (i = 0; i < 200 && txDataValid !== 1'b1; i++) tick(1);
				tick(8);
			end
		join
		if (rg) tick(6);
		chk("tx valid", 1, txDataValid);
		chk("tx nibble", n, txNibble);
		chk("tx error", e, txError);
		tick(4);
	endtask
	// leave mii only outside a high phase of the generated clock
	task automatic set_mode(input mode_e m);
		if (txClkOut === 1'b1) begin
			@(negedge txClkOut);
			#2;
		end
		modeSel = m;
	endtask
	task automatic t_rmii();
		int i;
		lineErr = 1'b0;
		lineNibble = 4'h6;
		lineValid = 1'b1;
		tick(1);
		lineValid = 1'b0;
		for (i = 0; i < 60 && rxCtrl !== 1'b1; i++) tick(1);
		chk("rmii valid", 1, rxCtrl);
		chk("rmii data", 5'h02, rxData);
		chk("rmii rxclk", 0, rxClk);
		tick(8);
		chk("rmii idle", 0, rxCtrl);
		lineActive = 1'b1;
		fullDuplex = 1'b0;
		mdl.level(1'b1);
		tick(6);
		chk("rmii carrier", 1, rxCtrl);
		chk("rmii col", 0, collision);
		lineActive = 1'b0;
		fullDuplex = 1'b1;
		mdl.level(1'b0);
		tick(6);
	endtask
	initial begin
		rst_n = 1'b0;
		modeSel = MODE_MII;
		speedFast = 1'b1;
		fullDuplex = 1'b1;
		lineActive = 1'b0;
		lineValid = 1'b0;
		lineErr = 1'b0;
		lineNibble = 4'h0;
		repeat (4) @(posedge clk_sys);
		#2;
		t_reset();
		t_txclk(1'b1, FAST_HALF, 40);
		t_rx(4'h5, 1'b0);
		t_rx(4'ha, 1'b1);
		t_col();
		t_txclk(1'b0, SLOW_HALF, 200);
		t_fill();
		t_tx(1'b0, 4'h9, 1'b0);
		set_mode(MODE_RMII);
		t_rmii();
		modeSel = MODE_RGMII;
		tick(6);
		t_tx(1'b1, 4'h3, 1'b0);
		t_tx(1'b1, 4'hc, 1'b1);
		give_verdict();
	end
endmodule
